// *** design/aqpo_pkg.sv ***
// What this block does
// R1: after power-up, send revolution count once, then in-revolution position.
// R2: after the burst, output tracks shaft motion like an incremental encoder.
// R3: revolution count at 100kHz quadrature; A leads B if positive, else lags.
// R4: host decodes sign from A/B phase and counts rising edges of A.
// R5: position as 100kHz quadrupled edges; direction follows revolution sign.
// R6: host counts every edge of A and B during the position burst.
// R7: incremental mode: A leads B forward, lags B in reverse.
// R8: incremental mode: 2048 pulses per revolution on each of A and B.
// R9: one index pulse on Z per revolution; its width is not fixed.
// R10: host counts both edges of A and B for fourfold resolution.
// R11: 13-bit position within a revolution plus a 13-bit revolution counter.
// R12: first power-on with battery and no history raises system-failure alarm.
// R13: revolution clear command in test mode clears the pending alarms.
// R14: after a position-loss alarm the operator re-establishes the origin.
package aqpo_pkg;

   localparam int POS_W = 13;
   localparam int REV_W = 13;
   localparam int CNT_W = REV_W + 2;

   localparam int CLK_HZ          = 125000000;
   localparam int BURST_PULSE_HZ  = 100000;
   localparam int EDGES_PER_PULSE = 4;
   // quarter-cycle spacing, rounded up so the pulse rate never exceeds 100kHz
   localparam int STEP_CYC = (CLK_HZ + BURST_PULSE_HZ * EDGES_PER_PULSE - 1)
                             / (BURST_PULSE_HZ * EDGES_PER_PULSE);
   localparam int INC_STEP_CYC = 8;
   localparam int GAP_STEPS    = 8;
   localparam int GAP_W        = 4;

   localparam logic [POS_W-1:0] INDEX_POS = 13'h0000;
   localparam logic [1:0]       QUAD_INIT = 2'h0;

   typedef enum logic [2:0] {
      AQPO_WAIT,
      AQPO_SEND_REV,
      AQPO_GAP,
      AQPO_SEND_ABS,
      AQPO_INCR
   } aqpo_state_e;

   typedef struct packed {
      logic             valid;
      logic [POS_W-1:0] pos;
      logic [REV_W-1:0] reverse_rotation;
   } aqpo_enc_s;

   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } aqpo_phase_s;

   typedef struct packed {
      logic absolute_system_failure_alarm;
      logic revolution_counter_overflow_alarm;
      logic revolution_data_error_alarm;
   } aqpo_alarm_s;

   // forward stepping of the count makes A lead B by a quarter cycle
   function automatic logic [1:0] quadToAB(input logic [1:0] q);
      case (q)
         2'h0:    quadToAB = 2'h0;
         2'h1:    quadToAB = 2'h2;
         2'h2:    quadToAB = 2'h3;
         default: quadToAB = 2'h1;
      endcase
   endfunction

endpackage

// *** design/aqpo_step_div.sv ***
`timescale 1ns/1ps
module aqpo_step_div #(
   parameter int DIV = 313
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // control
   input  wire logic run,
   output logic      tick
);
   localparam int W = $clog2(DIV + 1);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + W'(1);
         tick  <= 1'b0;
      end
   end
endmodule

// *** design/aqpo_core.sv ***
`timescale 1ns/1ps
module aqpo_core (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // encoder side, same clock
   input  wire aqpo_pkg::aqpo_enc_s enc,
   input  wire logic                powerReady,
   input  wire logic                batteryFitted,
   input  wire logic                historyLost,
   input  wire logic                revOverflow,
   input  wire logic                revDataError,
   // test mode command
   input  wire logic                testMode,
   input  wire logic                revolution_clear_test_command,
   // phase outputs
   output aqpo_pkg::aqpo_phase_s    phase,
   // alarms and status
   output aqpo_pkg::aqpo_alarm_s    alarm,
   output logic                     incrMode
);
   typedef struct packed {
      aqpo_pkg::aqpo_state_e      st;
      logic                       negRev;
      logic [aqpo_pkg::REV_W-1:0] snapRev;
      logic [aqpo_pkg::POS_W-1:0] snapPos;
      logic [aqpo_pkg::CNT_W-1:0] remain;
      logic [aqpo_pkg::POS_W-1:0] outPos;
      logic [1:0]                 quad;
      logic [aqpo_pkg::GAP_W-1:0] gapCnt;
      logic                       gapToIncr;
      logic                       strapDone;
      aqpo_pkg::aqpo_alarm_s      alarm;
      aqpo_pkg::aqpo_phase_s      phase;
      logic                       incrMode;
   } aqpo_core_s;

   logic [1:0]                 rstSync_q;
   logic                       rstn;
   aqpo_core_s                 core_q;
   aqpo_core_s                 core_d;
   logic                       burstTick;
   logic                       incTick;
   logic [aqpo_pkg::REV_W-1:0] revMag;
   logic [aqpo_pkg::POS_W-1:0] diff;

   // async assert, synchronous release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstSync_q <= 2'h0;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstn = rstSync_q[1];

   aqpo_step_div #(.DIV(aqpo_pkg::STEP_CYC)) u_burstDiv (
      .clk  (clk),
      .rstn (rstn),
      .run  (core_q.st == aqpo_pkg::AQPO_SEND_REV ||
             core_q.st == aqpo_pkg::AQPO_GAP ||
             core_q.st == aqpo_pkg::AQPO_SEND_ABS),
      .tick (burstTick)
   );

   aqpo_step_div #(.DIV(aqpo_pkg::INC_STEP_CYC)) u_incDiv (
      .clk  (clk),
      .rstn (rstn),
      .run  (core_q.st == aqpo_pkg::AQPO_INCR),
      .tick (incTick)
   );

   // magnitude of the signed revolution count
   assign revMag = enc.reverse_rotation[aqpo_pkg::REV_W-1] ? (~enc.reverse_rotation + 13'h0001)
                                               : enc.reverse_rotation; // R11
   assign diff   = enc.pos - core_q.outPos;

   always_comb begin
      core_d = core_q;
      case (core_q.st)
         aqpo_pkg::AQPO_WAIT: begin
            if (powerReady && enc.valid) begin
               // snapshot taken once, so motion during the burst is not lost
               core_d.negRev  = enc.reverse_rotation[aqpo_pkg::REV_W-1]; // R3
               core_d.snapRev = enc.reverse_rotation; // R11
               core_d.snapPos = enc.pos; // R11
               core_d.remain  = {revMag, 2'h0}; // R3
               core_d.st      = aqpo_pkg::AQPO_SEND_REV; // R1
            end
         end
         aqpo_pkg::AQPO_SEND_REV: begin
            if (core_q.remain == '0) begin
               core_d.gapCnt    = '0;
               core_d.gapToIncr = 1'b0;
               core_d.st        = aqpo_pkg::AQPO_GAP; // R1
            end else if (burstTick) begin
               core_d.remain = core_q.remain - 15'h0001;
               core_d.quad   = core_q.negRev ? core_q.quad - 2'h1
                                             : core_q.quad + 2'h1; // R3
            end
         end
         aqpo_pkg::AQPO_GAP: begin
            if (burstTick) begin
               core_d.gapCnt = core_q.gapCnt + 4'h1;
               if (core_q.gapCnt == 4'(aqpo_pkg::GAP_STEPS - 1)) begin
                  if (core_q.gapToIncr) begin
                     core_d.outPos = core_q.snapPos;
                     core_d.st     = aqpo_pkg::AQPO_INCR; // R2
                  end else begin
                     core_d.remain = {2'h0, core_q.snapPos};
                     core_d.st     = aqpo_pkg::AQPO_SEND_ABS; // R1
                  end
               end
            end
         end
         aqpo_pkg::AQPO_SEND_ABS: begin
            if (core_q.remain == '0) begin
               core_d.gapCnt    = '0;
               core_d.gapToIncr = 1'b1;
               core_d.st        = aqpo_pkg::AQPO_GAP;
            end else if (burstTick) begin
               core_d.remain = core_q.remain - 15'h0001;
               core_d.quad   = core_q.negRev ? core_q.quad - 2'h1
                                             : core_q.quad + 2'h1; // R5
            end
         end
         aqpo_pkg::AQPO_INCR: begin
            // one position step is one edge: 8192 edges, 2048 pulses a turn
            if (incTick && diff != '0) begin
               if (!diff[aqpo_pkg::POS_W-1]) begin
                  core_d.outPos = core_q.outPos + 13'h0001; // R8
                  core_d.quad   = core_q.quad + 2'h1; // R7
               end else begin
                  core_d.outPos = core_q.outPos - 13'h0001; // R8
                  core_d.quad   = core_q.quad - 2'h1; // R7
               end
            end
         end
         default: begin
            core_d.st = aqpo_pkg::AQPO_WAIT;
         end
      endcase

      // alarms: a set in the same cycle as the clear wins
      if (testMode && revolution_clear_test_command) begin
         core_d.alarm = '0; // R13
      end
      if (!core_q.strapDone && powerReady) begin
         core_d.strapDone = 1'b1;
         if (batteryFitted && historyLost) begin
            core_d.alarm.absolute_system_failure_alarm = 1'b1; // R12
         end
      end
      if (revOverflow) begin
         core_d.alarm.revolution_counter_overflow_alarm = 1'b1;
      end
      if (revDataError) begin
         core_d.alarm.revolution_data_error_alarm = 1'b1;
      end

      {core_d.phase.a, core_d.phase.b} = aqpo_pkg::quadToAB(core_d.quad);
      // index is a level while on the zero position; width follows speed
      core_d.phase.z  = (core_d.st == aqpo_pkg::AQPO_INCR) &&
                        (core_d.outPos == aqpo_pkg::INDEX_POS); // R9
      core_d.incrMode = (core_d.st == aqpo_pkg::AQPO_INCR);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         core_q       <= '0;
         core_q.st    <= aqpo_pkg::AQPO_WAIT;
         core_q.quad  <= aqpo_pkg::QUAD_INIT;
      end else begin
         core_q <= core_d;
      end
   end

   assign phase    = core_q.phase;
   assign alarm    = core_q.alarm;
   assign incrMode = core_q.incrMode;

   // helper logic read only by the checks below
   localparam int MIN_GAP = aqpo_pkg::STEP_CYC - 1;
   logic [9:0]                 sinceEdge_q;
   logic [aqpo_pkg::CNT_W-1:0] burstEdges_q;
   logic                       edgeNow;
   assign edgeNow = core_d.quad != core_q.quad;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sinceEdge_q  <= '0;
         burstEdges_q <= '0;
      end else begin
         sinceEdge_q  <= edgeNow ? 10'h000 :
                         (&sinceEdge_q ? sinceEdge_q : sinceEdge_q + 10'h001);
         if (core_q.st == aqpo_pkg::AQPO_GAP) begin
            burstEdges_q <= '0;
         end else if (edgeNow) begin
            burstEdges_q <= burstEdges_q + 15'h0001;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_quad_single_edge: assert property ( // R7
      !($changed(phase.a) && $changed(phase.b)))
      else $error("both phases moved in one cycle");
   // A rising with B low means A leads; with B high, A lags
   a_rev_direction: assert property ( // R3
      (core_q.st == aqpo_pkg::AQPO_SEND_REV && $rose(phase.a)) |->
      phase.b == core_q.negRev)
      else $error("revolution burst stepped the wrong way");
   a_abs_direction: assert property ( // R5
      (core_q.st == aqpo_pkg::AQPO_SEND_ABS && $rose(phase.a)) |->
      phase.b == core_q.negRev)
      else $error("position burst stepped the wrong way");
   a_burst_rate: assert property ( // R3
      (core_q.st != aqpo_pkg::AQPO_INCR && edgeNow) |->
      sinceEdge_q >= MIN_GAP)
      else $error("burst edges closer than a quarter of 10 us");
   a_rev_edge_count: assert property ( // R1
      (core_q.st == aqpo_pkg::AQPO_SEND_REV &&
       core_d.st == aqpo_pkg::AQPO_GAP) |->
      burstEdges_q == {(core_q.negRev ? ~core_q.snapRev + 13'h0001
                                      : core_q.snapRev), 2'h0})
      else $error("revolution burst edge count wrong");
   a_abs_edge_count: assert property ( // R5
      (core_q.st == aqpo_pkg::AQPO_SEND_ABS &&
       core_d.st == aqpo_pkg::AQPO_GAP) |->
      burstEdges_q == {2'h0, core_q.snapPos})
      else $error("position burst edge count wrong");
   a_incr_sticks: assert property ( // R2
      core_q.st == aqpo_pkg::AQPO_INCR |=> core_q.st == aqpo_pkg::AQPO_INCR)
      else $error("left incremental mode");
   a_incr_step: assert property ( // R8
      (core_q.st == aqpo_pkg::AQPO_INCR && edgeNow) |=>
      (core_q.outPos - $past(core_q.outPos) == 13'h0001) ||
      ($past(core_q.outPos) - core_q.outPos == 13'h0001))
      else $error("incremental edge did not match one position step");
   a_index_zero: assert property ( // R9
      phase.z |-> (core_q.st == aqpo_pkg::AQPO_INCR &&
                   core_q.outPos == aqpo_pkg::INDEX_POS))
      else $error("index pulse away from zero position");
   a_alarm_clear: assert property ( // R13
      (testMode && revolution_clear_test_command && !revOverflow &&
       !revDataError && core_q.strapDone) |=> alarm == '0)
      else $error("clear command did not clear alarms");
   a_first_alarm: assert property ( // R12
      (!core_q.strapDone && powerReady && batteryFitted && historyLost)
      |=> alarm.absolute_system_failure_alarm)
      else $error("first power-on alarm not raised");

   c_neg_burst: cover property (
      core_q.st == aqpo_pkg::AQPO_SEND_REV && core_q.negRev && edgeNow);
   c_reach_incr: cover property (
      core_q.st == aqpo_pkg::AQPO_GAP ##1 core_q.st == aqpo_pkg::AQPO_INCR);
   c_index_seen: cover property ($rose(phase.z));
   c_alarm_cleared: cover property ($fell(alarm.absolute_system_failure_alarm));
endmodule

// *** bench/aqpo_host_model.sv ***
`timescale 1ns/1ps
module aqpo_host_model #(
   parameter int IDLE_CYC = 1500
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // phase lines from the device
   input  wire aqpo_pkg::aqpo_phase_s phase,
   // one report per burst or move
   output logic                       segValid,
   output int                         segEdges,
   output int                         segARise,
   output int                         segZRise,
   output int                         segMinIdle,
   output int                         badSteps
);
   logic [1:0] prevIdx;
   logic [1:0] idx;
   logic [1:0] step;
   logic       prevA;
   logic       prevZ;
   logic       active;
   int         idle;
   int         cntEdges;
   int         cntA;
   int         cntZ;
   int         minIdle;

   // gray position of the pair, forward order 00,10,11,01
   always_comb begin
      case ({phase.a, phase.b})
         2'h0:    idx = 2'h0;
         2'h2:    idx = 2'h1;
         2'h3:    idx = 2'h2;
         default: idx = 2'h3;
      endcase
      step = idx - prevIdx;
   end

   // a gap much longer than one burst step closes the current count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prevIdx  <= 2'h0;
         prevA    <= 1'b0;
         prevZ    <= 1'b0;
         active   <= 1'b0;
         idle     <= 0;
         cntEdges <= 0;
         cntA     <= 0;
         cntZ     <= 0;
         minIdle  <= 32'h7FFFFFFF;
         segValid <= 1'b0;
         badSteps <= 0;
      end else begin
         segValid <= 1'b0;
         prevIdx  <= idx;
         prevA    <= phase.a;
         prevZ    <= phase.z;
         if (step == 2'h1) cntEdges <= cntEdges + 1;
         if (step == 2'h3) cntEdges <= cntEdges - 1;
         if (step == 2'h2) badSteps <= badSteps + 1;
         if (phase.a && !prevA) cntA <= cntA + 1;
         if (phase.z && !prevZ) cntZ <= cntZ + 1;
         if (step != 2'h0) begin
            active <= 1'b1;
            idle   <= 0;
            if (active && idle < minIdle) minIdle <= idle;
         end else if (active && idle == IDLE_CYC) begin
            segValid   <= 1'b1;
            segEdges   <= cntEdges;
            segARise   <= cntA;
            segZRise   <= cntZ;
            segMinIdle <= minIdle;
            active     <= 1'b0;
            cntEdges   <= 0;
            cntA       <= 0;
            cntZ       <= 0;
            minIdle    <= 32'h7FFFFFFF;
         end else begin
            idle <= idle + 1;
         end
      end
   end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   typedef struct {int edges; int aRise; int zRise; bit slow;} aqpo_note_s;
   logic                  clk;
   logic                  resetn;
   aqpo_pkg::aqpo_enc_s   enc;
   logic                  powerReady, batteryFitted, historyLost;
   logic                  revOverflow, revDataError, testMode, clearCmd;
   aqpo_pkg::aqpo_phase_s phase;
   aqpo_pkg::aqpo_alarm_s alarm;
   logic                  incrMode, segValid;
   int                    segEdges, segARise, segZRise, segMinIdle, badSteps;
   int                    failCount, samplesChecked, seenSegs, cycleCount;
   int                    seed, r, p, d;
   aqpo_note_s            notes[$];
   aqpo_note_s            n;

   aqpo_core DUT (.clk(clk), .resetn(resetn), .enc(enc),
      .powerReady(powerReady), .batteryFitted(batteryFitted),
      .historyLost(historyLost), .revOverflow(revOverflow),
      .revDataError(revDataError), .testMode(testMode),
      .revolution_clear_test_command(clearCmd), .phase(phase),
      .alarm(alarm), .incrMode(incrMode));

   aqpo_host_model host (.clk(clk), .resetn(resetn), .phase(phase),
      .segValid(segValid), .segEdges(segEdges), .segARise(segARise),
      .segZRise(segZRise), .segMinIdle(segMinIdle), .badSteps(badSteps));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] expv);
      samplesChecked++;
      if (seen !== expv) begin
         failCount++;
         $display("CHECK FAILED %s expected %0d seen %0d", what,
                  $signed(expv), $signed(seen));
      end
   endtask

   task automatic finalReport();
      if (failCount == 0 && samplesChecked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic note(input int e, input int a, input int z, input bit s);
      notes.push_back('{e, a, z, s});
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic waitSegs(input int k);
      while (seenSegs < k) @(posedge clk);
      tick(1);
   endtask

   task automatic waitIncr();
      while (incrMode !== 1'b1) @(posedge clk);
      tick(1);
   endtask

   task automatic move(input int target, input int e, input int a,
                       input int z);
      note(e, a, z, 1'b0);
      enc.pos = target[12:0];
      waitSegs(seenSegs + 1);
   endtask

   task automatic clearAlarms(input logic mode);
      testMode = mode;
      clearCmd = 1'b1;
      tick(1);
      clearCmd = 1'b0;
      testMode = 1'b0;
      tick(1);
   endtask

   always @(posedge clk) begin
      cycleCount++;
      if (cycleCount == 90000) begin
         failCount++;
         finalReport();
      end else if (segValid === 1'b1) begin
         seenSegs++;
         if (notes.size() == 0) begin
            check("unexpected burst", 32'h0, 32'h1);
         end else begin
            n = notes.pop_front();
            check("signed edges", segEdges, n.edges);
            if (n.aRise >= 0) check("a rises", segARise, n.aRise);
            if (n.zRise >= 0) check("z rises", segZRise, n.zRise);
            if (n.slow) check("burst spacing", segMinIdle >= 312, 1);
         end
      end
   end

   initial begin
      seed = 32'h38D8;
      {failCount, samplesChecked, seenSegs, cycleCount} = '0;
      resetn = 1'b0;
      enc = '0;
      {powerReady, revOverflow, revDataError, testMode, clearCmd} = '0;
      batteryFitted = 1'b1;
      historyLost = 1'b1;
      tick(3);
      resetn = 1'b1;
      tick(3);
      // revolution count -3, position 25, history lost
      enc = '{valid: 1'b1, pos: 13'h0019, reverse_rotation: 13'h1FFD};
      powerReady = 1'b1;
      note(-12, 3, -1, 1'b1);
      note(-25, -1, -1, 1'b1);
      tick(1);
      // snapshot already taken, later samples must not alter the burst
      enc.pos = 13'($random(seed));
      enc.reverse_rotation = 13'($random(seed));
      tick(1);
      check("first power alarm", alarm, 3'h4);
      clearAlarms(1'b0);
      check("clear outside test", alarm, 3'h4);
      clearAlarms(1'b1);
      check("clear in test", alarm, 3'h0);
      revOverflow = 1'b1;
      tick(1);
      revOverflow = 1'b0;
      revDataError = 1'b1;
      tick(1);
      revDataError = 1'b0;
      tick(1);
      check("fault alarms", alarm, 3'h3);
      clearAlarms(1'b1);
      check("fault clear", alarm, 3'h0);
      waitSegs(1);
      check("incr after count", incrMode, 1'b0);
      waitSegs(2);
      enc.pos = 13'h0019;
      enc.reverse_rotation = 13'h1FFD;
      waitIncr();
      move(13, -12, 3, 0);
      move(8001, -204, 51, 1);
      move(401, 592, 148, 1);
      d = $random(seed) % 50;
      if (d == 0) d = 7;
      move(401 + d, d, -1, -1);
      // second power-up, positive count, history kept
      resetn = 1'b0;
      powerReady = 1'b0;
      historyLost = 1'b0;
      enc.valid = 1'b0;
      tick(3);
      resetn = 1'b1;
      tick(3);
      r = 1 + ($unsigned($random(seed)) % 4);
      p = 1 + ($unsigned($random(seed)) % 40);
      // power ready alone must not start a burst from a stale sample
      powerReady = 1'b1;
      tick(20);
      enc = '{valid: 1'b1, pos: p[12:0], reverse_rotation: r[12:0]};
      note(4 * r, r, -1, 1'b1);
      note(p, -1, -1, 1'b1);
      waitSegs(seenSegs + 2);
      check("no history alarm", alarm, 3'h0);
      waitIncr();
      check("illegal steps", badSteps, 0);
      check("reports left", notes.size(), 0);
      finalReport();
   end
endmodule
